// *** wrap_coord_param_save.sv ***
// wrap coordinate checks, offset window, division marker and the
// RAM / non-volatile parameter image handling.
// assumes an external non-volatile word store with one-cycle read latency
// and step commands that come from logic on the same clock.
// Operation
// - range valid if span divides by range
// - range times gear ratio gives whole steps
// - invalid enabled range flags info, stops wrap
// - info at power-up or configure becomes alarm
// - offset ratio shifts window negative from home
// - step offset shifts window; home outside flags
// - marker at each even division from home
// - division count 1 to 536870911, reset 1
// - marker only while wrap enabled
// - bus writes land in RAM only
// - power-up copies image to RAM, then setup
// - save command copies RAM to image
// - power loss during save raises 41h
// - command runs on zero to one change
// - writing two runs now, restores one
// - range counted in tenths of a revolution
// - offset ratio 0 to 10000, 0.01 percent
`timescale 1ns/10ps
`default_nettype none
module wrap_coord_param_save #(
    parameter int unsigned  GEAR_W      = 16,
    parameter longint unsigned HOLD_CYCLES = wrap_pkg::NV_HOLD_CYCLES
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_param_wr,
    input  wire logic              i_param_rd,
    input  wire logic [15:0]       i_param_index,
    input  wire logic [31:0]       i_param_wdata,
    output logic [31:0]            o_param_rdata,
    output logic                   o_param_rvalid,
    input  wire logic [GEAR_W-1:0] i_gear_a,
    input  wire logic [GEAR_W-1:0] i_gear_b,
    input  wire logic              i_small_frame,
    input  wire logic              i_config_pulse,
    input  wire logic              i_step_valid,
    input  wire logic              i_step_dir,
    input  wire logic              i_power_fail_pin,
    output logic [2:0]             o_nv_addr,
    output logic                   o_nv_rd_en,
    output logic                   o_nv_wr_en,
    output logic [31:0]            o_nv_wdata,
    input  wire logic [31:0]       i_nv_rdata,
    output logic signed [31:0]     o_position,
    output logic                   o_wrap_division_marker,
    output logic                   o_wrap_setting_info,
    output logic                   o_wrap_alarm,
    output logic                   o_nv_alarm,
    output logic [7:0]             o_alarm_code,
    output logic                   o_nv_busy,
    output logic                   o_load_done
);
    import wrap_pkg::*;

    typedef struct packed {
        nv_state_t          st;
        logic [31:0]        en;
        logic [31:0]        range;
        logic [31:0]        ratio;
        logic [31:0]        ofs;
        logic [31:0]        divc;
        logic signed [31:0] pos;
        logic [31:0]        phase;
        logic [2:0]         cnt;
        logic [31:0]        hold;
        logic [2:0]         psync;
        logic               setup_pend;
        logic               wrap_alarm;
        logic               nv_alarm;
        logic               marker;
        logic [31:0]        rdata;
        logic               rvalid;
        logic [2:0]         nv_addr;
        logic               nv_rd;
        logic               nv_wr;
        logic [31:0]        nv_wdata;
        logic               load_done;
    } core_t;

    core_t              core_reg;
    core_t              core_next;
    logic               save_fire;
    logic [31:0]        save_data;
    logic [63:0]        steps_num;
    logic [63:0]        steps_den;
    logic [63:0]        range_steps;
    logic [63:0]        ratio_shift;
    logic signed [63:0] lower;
    logic signed [63:0] upper;
    logic [31:0]        interval;
    logic               cond1;
    logic               cond2;
    logic               home_in;
    logic               info;
    logic               wrap_on;
    logic               power_fail;

    function automatic logic divides(input logic [63:0] num,
                                     input logic [63:0] den);
        divides = (den != 64'h0) && ((num % den) == 64'h0);
    endfunction : divides

    function automatic logic [31:0] slot_value(input core_t c,
                                               input logic [2:0] s);
        if (s == 3'h0) slot_value = c.en;
        else if (s == 3'h1) slot_value = c.range;
        else if (s == 3'h2) slot_value = c.ratio;
        else if (s == 3'h3) slot_value = c.ofs;
        else slot_value = c.divc;
    endfunction : slot_value

    //======================================================================
    // maintenance command
    //======================================================================
    maint_cmd_trigger #(.CMD_INDEX(IDX_SAVE_ALL)) u_save_cmd (
        .i_core_clk    (i_core_clk),
        .i_rst_n       (i_rst_n),
        .i_param_wr    (i_param_wr),
        .i_param_index (i_param_index),
        .i_param_wdata (i_param_wdata),
        .o_fire        (save_fire),
        .o_cmd_data    (save_data)
    );

    //======================================================================
    // wrap range checks and window
    //======================================================================
    always_comb begin
        // range in tenths of a revolution
        steps_num = 64'(core_reg.range) * 64'(i_gear_b) * STEPS_PER_REV;
        steps_den = 64'(i_gear_a) * UNITS_PER_REV;
        range_steps = (steps_den != 64'h0) ? steps_num / steps_den : 64'h0;
        cond1 = divides(i_small_frame ? SPAN_SMALL : SPAN_STD,
                        64'(core_reg.range));
        cond2 = divides(steps_num, steps_den);
        ratio_shift = (range_steps * 64'(core_reg.ratio))
                      / 64'(RATIO_FULL);
        lower = $signed({{32{core_reg.ofs[31]}}, core_reg.ofs})
                - $signed(ratio_shift);
        upper = lower + $signed(range_steps) - 64'sd1;
        home_in = (lower <= 64'sd0) && (upper >= 64'sd0);
        info = core_reg.en[0] && !(cond1 && cond2 && home_in);
        wrap_on = core_reg.en[0] && !info && !core_reg.wrap_alarm;
        interval = (core_reg.divc != 32'h0)
                   ? 32'(range_steps / 64'(core_reg.divc))
                   : 32'(range_steps);
        if (interval == 32'h0) interval = 32'h1;
        power_fail = core_reg.psync[1] && core_reg.psync[2];
    end

    //======================================================================
    // next state
    //======================================================================
    always_comb begin
        core_next = core_reg;
        core_next.psync = {core_reg.psync[1:0], i_power_fail_pin};
        core_next.marker = 1'b0;
        core_next.rvalid = 1'b0;
        core_next.nv_rd = 1'b0;
        core_next.nv_wr = 1'b0;
        core_next.setup_pend = 1'b0;
        if (core_reg.setup_pend && info) begin
            core_next.wrap_alarm = 1'b1;
        end
        if (i_config_pulse && core_reg.st != ST_LOAD) begin
            core_next.setup_pend = 1'b1;
        end
        // parameter writes go to the RAM copy only
        if (i_param_wr && core_reg.st != ST_LOAD) begin
            if (i_param_index == IDX_WRAP_ENABLE) begin
                if (i_param_wdata[31:1] == 31'h0)
                    core_next.en = i_param_wdata;
            end else if (i_param_index == IDX_WRAP_RANGE) begin
                core_next.range = i_param_wdata;
            end else if (i_param_index == IDX_OFFSET_RATIO) begin
                if (i_param_wdata <= RATIO_FULL)
                    core_next.ratio = i_param_wdata;
            end else if (i_param_index == IDX_OFFSET_VALUE) begin
                if (i_param_wdata[31:29] == {3{i_param_wdata[31]}})
                    core_next.ofs = i_param_wdata;
            end else if (i_param_index == IDX_DIV_COUNT) begin
                if (i_param_wdata != 32'h0
                    && i_param_wdata <= DIV_COUNT_MAX)
                    core_next.divc = i_param_wdata;
            end
        end
        if (i_param_rd) begin
            core_next.rvalid = 1'b1;
            if (i_param_index == IDX_WRAP_ENABLE) core_next.rdata = core_reg.en;
            else if (i_param_index == IDX_WRAP_RANGE)
                core_next.rdata = core_reg.range;
            else if (i_param_index == IDX_OFFSET_RATIO)
                core_next.rdata = core_reg.ratio;
            else if (i_param_index == IDX_OFFSET_VALUE)
                core_next.rdata = core_reg.ofs;
            else if (i_param_index == IDX_DIV_COUNT)
                core_next.rdata = core_reg.divc;
            else if (i_param_index == IDX_SAVE_ALL)
                core_next.rdata = save_data;
            else core_next.rdata = 32'h0;
        end
        // step commands, window wrap and division marker
        if (i_step_valid && core_reg.st != ST_LOAD) begin
            if (i_step_dir) begin
                if (wrap_on && 64'(core_reg.pos) == upper)
                    core_next.pos = lower[31:0];
                else core_next.pos = core_reg.pos + 32'sd1;
                core_next.phase = (core_reg.phase + 32'h1 >= interval)
                                  ? 32'h0 : core_reg.phase + 32'h1;
            end else begin
                if (wrap_on && 64'(core_reg.pos) == lower)
                    core_next.pos = upper[31:0];
                else core_next.pos = core_reg.pos - 32'sd1;
                core_next.phase = (core_reg.phase == 32'h0)
                                  ? interval - 32'h1
                                  : core_reg.phase - 32'h1;
            end
            core_next.marker = wrap_on && core_next.phase == 32'h0;
        end
        case (core_reg.st)
            ST_LOAD: begin
                if (core_reg.cnt != 3'h0) begin
                    case (core_reg.cnt - 3'h1)
                        3'h0: core_next.en = i_nv_rdata;
                        3'h1: core_next.range = i_nv_rdata;
                        3'h2: core_next.ratio = i_nv_rdata;
                        3'h3: core_next.ofs = i_nv_rdata;
                        default: core_next.divc = i_nv_rdata;
                    endcase
                end
                if (core_reg.cnt == NUM_SLOTS) begin
                    core_next.st = ST_IDLE;
                    core_next.load_done = 1'b1;
                    core_next.setup_pend = 1'b1;
                end else begin
                    core_next.nv_rd = 1'b1;
                    core_next.nv_addr = core_reg.cnt;
                    core_next.cnt = core_reg.cnt + 3'h1;
                end
            end
            ST_IDLE: begin
                if (save_fire) begin
                    core_next.st = ST_SAVE;
                    core_next.cnt = 3'h1;
                    core_next.nv_wr = 1'b1;
                    core_next.nv_addr = 3'h0;
                    core_next.nv_wdata = slot_value(core_reg, 3'h0);
                end
            end
            ST_SAVE: begin
                if (core_reg.cnt == NUM_SLOTS) begin
                    core_next.st = ST_HOLD;
                    core_next.hold = 32'(HOLD_CYCLES - 1);
                end else begin
                    core_next.nv_wr = 1'b1;
                    core_next.nv_addr = core_reg.cnt;
                    core_next.nv_wdata = slot_value(core_reg, core_reg.cnt);
                    core_next.cnt = core_reg.cnt + 3'h1;
                end
            end
            ST_HOLD: begin
                core_next.hold = core_reg.hold - 32'h1;
                if (core_reg.hold == 32'h0) core_next.st = ST_IDLE;
            end
            default: core_next.st = ST_IDLE;
        endcase
        if ((core_reg.st == ST_SAVE || core_reg.st == ST_HOLD) && power_fail) begin
            core_next.nv_alarm = 1'b1;
            core_next.nv_wr = 1'b0;
            core_next.st = ST_IDLE;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_reg <= '{st: ST_LOAD, en: RST_WRAP_ENABLE,
                          range: RST_WRAP_RANGE, ratio: RST_OFFSET_RATIO,
                          ofs: RST_OFFSET_VALUE, divc: RST_DIV_COUNT,
                          default: '0};
        end else begin
            core_reg <= core_next;
        end
    end

    assign o_param_rdata          = core_reg.rdata;
    assign o_param_rvalid         = core_reg.rvalid;
    assign o_nv_addr              = core_reg.nv_addr;
    assign o_nv_rd_en             = core_reg.nv_rd;
    assign o_nv_wr_en             = core_reg.nv_wr;
    assign o_nv_wdata             = core_reg.nv_wdata;
    assign o_position             = core_reg.pos;
    assign o_wrap_division_marker = core_reg.marker;
    assign o_wrap_setting_info    = info;
    assign o_wrap_alarm           = core_reg.wrap_alarm;
    assign o_nv_alarm             = core_reg.nv_alarm;
    assign o_alarm_code = core_reg.nv_alarm ? ALARM_NV_ABORT
                        : (core_reg.wrap_alarm ? ALARM_WRAP_SET : 8'h00);
    assign o_nv_busy = (core_reg.st == ST_SAVE) || (core_reg.st == ST_HOLD);
    assign o_load_done            = core_reg.load_done;

    //======================================================================
    // checks
    //======================================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    bad_span_a: assert property (
        (core_reg.en[0] && !cond1) |-> o_wrap_setting_info)
        else $error("bad span not flagged");
    info_escalate_a: assert property (
        (i_config_pulse && core_reg.st == ST_IDLE && info
         && $stable(core_reg.range)) |=> ##1 o_wrap_alarm)
        else $error("configure did not raise wrap alarm");
    marker_gate_a: assert property (
        o_wrap_division_marker |-> $past(core_reg.en[0]))
        else $error("marker while wrap disabled");
    wrap_upper_a: assert property (
        (wrap_on && i_step_valid && i_step_dir && core_reg.st != ST_LOAD
         && 64'(o_position) == upper) |=> (o_position == $past(lower[31:0])))
        else $error("upper boundary did not wrap");
    save_burst_a: assert property (
        (save_fire && core_reg.st == ST_IDLE && !power_fail)
        |=> (o_nv_wr_en && o_nv_addr == 3'h0) ##1 o_nv_wr_en[*4])
        else $error("save burst incomplete");
    nv_abort_a: assert property (
        (o_nv_busy && power_fail) |=> (o_nv_alarm && o_alarm_code == 8'h41))
        else $error("aborted save without alarm");
    div_range_a: assert property (
        (i_param_wr && i_param_index == IDX_DIV_COUNT && i_param_wdata == 32'h0)
        |=> $stable(core_reg.divc))
        else $error("zero division count accepted");
    load_copy_a: assert property (
        (core_reg.st == ST_LOAD && core_reg.cnt == 3'h2)
        |=> (core_reg.range == $past(i_nv_rdata)))
        else $error("image word not copied to RAM");
endmodule : wrap_coord_param_save
`default_nettype wire

// *** wrap_pkg.sv ***
// package of register indexes, reset values and timing counts for the
// wrap coordinate and parameter save block.
// assumes a single 200 MHz core clock.
//==========================================================================
// wrap_pkg
//==========================================================================
package wrap_pkg;
    // parameter indexes on the fieldbus parameter port
    localparam logic [15:0] IDX_WRAP_ENABLE  = 16'h41c7;
    localparam logic [15:0] IDX_WRAP_RANGE   = 16'h41c9;
    localparam logic [15:0] IDX_OFFSET_RATIO = 16'h41cb;
    localparam logic [15:0] IDX_OFFSET_VALUE = 16'h41cc;
    localparam logic [15:0] IDX_DIV_COUNT    = 16'h41cd;
    localparam logic [15:0] IDX_SAVE_ALL     = 16'h40c9;
    // reset values
    localparam logic [31:0] RST_WRAP_ENABLE  = 32'h0000_0001;
    localparam logic [31:0] RST_WRAP_RANGE   = 32'h0000_000a;
    localparam logic [31:0] RST_OFFSET_RATIO = 32'h0000_1388;
    localparam logic [31:0] RST_OFFSET_VALUE = 32'h0000_0000;
    localparam logic [31:0] RST_DIV_COUNT    = 32'h0000_0001;
    // limits
    localparam logic [31:0] DIV_COUNT_MAX    = 32'h1fff_ffff;
    localparam logic [31:0] RATIO_FULL       = 32'h0000_2710;
    // sensor coordinate span in 0.1 rev units: 1,800 rev and 900 rev
    localparam logic [63:0] SPAN_STD         = 64'h0000_0000_0000_4650;
    localparam logic [63:0] SPAN_SMALL       = 64'h0000_0000_0000_2328;
    localparam logic [63:0] STEPS_PER_REV    = 64'h0000_0000_0000_2710;
    localparam logic [63:0] UNITS_PER_REV    = 64'h0000_0000_0000_000a;
    // maintenance command data values
    localparam logic [31:0] CMD_IDLE         = 32'h0000_0000;
    localparam logic [31:0] CMD_ARM          = 32'h0000_0001;
    localparam logic [31:0] CMD_NOW          = 32'h0000_0002;
    // alarm codes; the wrap code value is arbitrary
    localparam logic [7:0]  ALARM_NV_ABORT   = 8'h41;
    localparam logic [7:0]  ALARM_WRAP_SET   = 8'h5a;
    // non-volatile image slots
    localparam logic [2:0]  NUM_SLOTS        = 3'h5;
    // power hold after a save
    localparam longint unsigned CLK_FREQ_HZ    = 200_000_000;
    localparam longint unsigned NV_HOLD_TIME_S = 5;
    localparam longint unsigned NV_HOLD_CYCLES = NV_HOLD_TIME_S * CLK_FREQ_HZ;
    typedef enum logic [3:0] {
        ST_LOAD = 4'b0001,
        ST_IDLE = 4'b0010,
        ST_SAVE = 4'b0100,
        ST_HOLD = 4'b1000
    } nv_state_t;
endpackage : wrap_pkg

// *** maint_cmd_trigger.sv ***
// one maintenance command data word with its two trigger methods.
// assumes parameter writes are one-cycle strobes on the core clock.
`timescale 1ns/10ps
`default_nettype none
//==========================================================================
// maint_cmd_trigger
//==========================================================================
module maint_cmd_trigger #(
    parameter logic [15:0] CMD_INDEX = wrap_pkg::IDX_SAVE_ALL
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_param_wr,
    input  wire logic [15:0] i_param_index,
    input  wire logic [31:0] i_param_wdata,
    output logic             o_fire,
    output logic [31:0]      o_cmd_data
);
    import wrap_pkg::*;

    typedef struct packed {
        logic [31:0] data;
        logic        fire;
    } trig_t;

    trig_t r_reg;
    trig_t r_next;

    always_comb begin
        r_next = r_reg;
        r_next.fire = 1'b0;
        if (i_param_wr && i_param_index == CMD_INDEX) begin
            if (i_param_wdata == CMD_NOW) begin
                r_next.fire = 1'b1;
                r_next.data = CMD_ARM;
            end else begin
                r_next.fire = (i_param_wdata == CMD_ARM)
                              && (r_reg.data == CMD_IDLE);
                r_next.data = i_param_wdata;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_fire     = r_reg.fire;
    assign o_cmd_data = r_reg.data;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    rearm_blocked_a: assert property (
        (i_param_wr && i_param_index == CMD_INDEX && i_param_wdata == CMD_ARM
         && o_cmd_data != CMD_IDLE) |=> !o_fire)
        else $error("write of one re-ran a command");
    write_two_a: assert property (
        (i_param_wr && i_param_index == CMD_INDEX && i_param_wdata == CMD_NOW)
        |=> (o_fire && o_cmd_data == CMD_ARM))
        else $error("write of two did not run and restore");
endmodule : maint_cmd_trigger
`default_nettype wire

// *** nv_store_model.sv ***
// non-volatile word store model with a preset image and one-cycle reads.
// assumes the block's nv port runs on the same core clock.
`timescale 1ns/10ps
`default_nettype none
//==========================================================================
// nv_store_model
//==========================================================================
module nv_store_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_rd_en,
    input  wire logic        i_wr_en,
    input  wire logic [2:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    output logic      [31:0] o_rdata
);
    logic [31:0] mem [0:4] = '{32'h1, 32'ha, 32'h1388, 32'h0, 32'h3};
    logic [31:0] idle_q = 32'h0;
    // the read strobe is a register of the block, so the word is shown
    // in the strobe's own cycle; data lines toggle when no read is answered
    always @(posedge i_core_clk) begin
        if (i_wr_en)
            mem[i_addr] <= i_wdata;
        idle_q <= ~idle_q;
    end
    assign o_rdata = i_rd_en ? mem[i_addr] : idle_q;
endmodule : nv_store_model
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the wrap coordinate and parameter save block.
// assumes the nv store model beside it and a short power hold count.
`timescale 1ns/10ps
`default_nettype none
//==========================================================================
// tb_top
//==========================================================================
module tb_top;
    import wrap_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, cfg = 0, sv = 0, pf = 0, sm = 0;
    logic dir = 1;
    logic [15:0] idx = 16'h0, ga = 16'h1, gb = 16'h1;
    logic [31:0] wd = 32'h0, rdat, nvw, nvr;
    logic [2:0] na;
    logic rv, nre, nwe, mk, inf, wal, nal, busy, ld;
    logic [7:0] code;
    int fails = 0, n_tests = 0, cyc = 0, marks = 0;
    always #2.5 clk = ~clk;
    wrap_coord_param_save #(.HOLD_CYCLES(20)) u_dut (.i_core_clk(clk),
        .i_rst_n(rst_n), .i_param_wr(wr), .i_param_rd(rd),
        .i_param_index(idx), .i_param_wdata(wd), .o_param_rdata(rdat),
        .o_param_rvalid(rv), .i_gear_a(ga), .i_gear_b(gb),
        .i_small_frame(sm), .i_config_pulse(cfg), .i_step_valid(sv),
        .i_step_dir(dir), .i_power_fail_pin(pf), .o_nv_addr(na),
        .o_nv_rd_en(nre), .o_nv_wr_en(nwe), .o_nv_wdata(nvw),
        .i_nv_rdata(nvr), .o_position(), .o_wrap_division_marker(mk),
        .o_wrap_setting_info(inf), .o_wrap_alarm(wal), .o_nv_alarm(nal),
        .o_alarm_code(code), .o_nv_busy(busy), .o_load_done(ld));
    nv_store_model u_nv (.i_core_clk(clk), .i_rd_en(nre), .i_wr_en(nwe),
        .i_addr(na), .i_wdata(nvw), .o_rdata(nvr));
    always @(posedge clk) begin
        cyc++;
        if (mk === 1'b1)
            marks++;
        if (cyc == 60000) begin
            fails++;
            test_done();
        end
    end
    //======================================================================
    // tasks
    //======================================================================
    task test_done();
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        n_tests++;
        if (seen !== ex) begin
            fails++;
            $display("unexpected %s exp %h seen %h", nm, ex, seen);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk) #1;
    endtask : tick
    task wrt(input logic [15:0] i, input logic [31:0] d);
        wr = 1;
        idx = i;
        wd = d;
        tick(1);
        wr = 0;
        tick(1);
    endtask : wrt
    task rdc(input logic [15:0] i, input logic [31:0] ex);
        rd = 1;
        idx = i;
        tick(1);
        rd = 0;
        chk("rvalid", {31'h0, rv}, 32'h1);
        chk("rdata", rdat, ex);
    endtask : rdc
    task wri(input logic [15:0] i, input logic [31:0] d, input logic ex);
        wrt(i, d);
        tick(1);
        chk("info", {31'h0, inf}, {31'h0, ex});
    endtask : wri
    task wait_idle();
        for (int k = 0; k < 200 && busy !== 1'b0; k++)
            tick(1);
        chk("busy", {31'h0, busy}, 32'h0);
    endtask : wait_idle
    task steps(input int n);
        sv = 1;
        tick(n);
        sv = 0;
        tick(3);
    endtask : steps
    //======================================================================
    // sequence
    //======================================================================
    initial begin
        tick(12);
        rst_n = 1;
        for (int k = 0; k < 50 && ld !== 1'b1; k++)
            tick(1);
        rdc(IDX_DIV_COUNT, 32'h3);
        wrt(IDX_DIV_COUNT, 32'h0);
        rdc(IDX_DIV_COUNT, 32'h3);
        wrt(IDX_DIV_COUNT, 32'h2000_0000);
        rdc(IDX_DIV_COUNT, 32'h3);
        wrt(IDX_DIV_COUNT, DIV_COUNT_MAX);
        rdc(IDX_DIV_COUNT, DIV_COUNT_MAX);
        wrt(IDX_OFFSET_RATIO, 32'h2711);
        rdc(IDX_OFFSET_RATIO, 32'h1388);
        wrt(IDX_DIV_COUNT, 32'h4);
        chk("nv div", u_nv.mem[4], 32'h3);
        wrt(IDX_SAVE_ALL, CMD_NOW);
        tick(3);
        chk("busy", {31'h0, busy}, 32'h1);
        wait_idle();
        chk("nv div", u_nv.mem[4], 32'h4);
        rdc(IDX_SAVE_ALL, CMD_ARM);
        wrt(IDX_SAVE_ALL, CMD_ARM);
        tick(4);
        chk("busy", {31'h0, busy}, 32'h0);
        wrt(IDX_SAVE_ALL, CMD_IDLE);
        wrt(IDX_SAVE_ALL, CMD_ARM);
        tick(3);
        chk("busy", {31'h0, busy}, 32'h1);
        wait_idle();
        marks = 0;
        steps(5000);
        chk("pos", u_dut.o_position, 32'hffff_ec78);
        steps(5000);
        chk("pos", u_dut.o_position, 32'h0);
        chk("marks", marks, 32'h4);
        dir = 0;
        steps(5001);
        chk("pos", u_dut.o_position, 32'h0000_1387);
        dir = 1;
        wrt(IDX_WRAP_ENABLE, 32'h0);
        marks = 0;
        steps(2500);
        chk("marks", marks, 32'h0);
        wri(IDX_WRAP_ENABLE, 32'h1, 1'b0);
        wri(IDX_OFFSET_VALUE, 32'h1770, 1'b1);
        wri(IDX_OFFSET_VALUE, 32'h0, 1'b0);
        wri(IDX_WRAP_RANGE, 32'h2710, 1'b1);
        wri(IDX_WRAP_RANGE, 32'h4650, 1'b0);
        sm = 1;
        tick(2);
        chk("info", {31'h0, inf}, 32'h1);
        sm = 0;
        ga = 16'h3;
        wri(IDX_WRAP_RANGE, 32'h90, 1'b0);
        wri(IDX_WRAP_RANGE, 32'ha, 1'b1);
        gb = 16'h3;
        tick(1);
        chk("info", {31'h0, inf}, 32'h0);
        gb = 16'h1;
        wrt(IDX_SAVE_ALL, CMD_NOW);
        tick(4);
        pf = 1;
        tick(6);
        chk("code", {24'h0, code}, {24'h0, ALARM_NV_ABORT});
        chk("nvalarm", {31'h0, nal}, 32'h1);
        pf = 0;
        cfg = 1;
        tick(1);
        cfg = 0;
        tick(3);
        chk("walarm", {31'h0, wal}, 32'h1);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
